// File: pkg/u2dc_pkg.sv
package u2dc_pkg;
    localparam int         U2DC_PORTS      = 4;
    localparam int         U2DC_CELL_BYTES = 53;
    localparam int         U2DC_ADDR_W     = 5;
    localparam int         U2DC_DATA_W     = 8;
    localparam logic [4:0] U2DC_PORT1_ADDR = 5'h00;
    localparam logic       U2DC_TGL_RST    = 1'b0;
    localparam logic       U2DC_OE_RST     = 1'b0;

    typedef enum logic {
        U2DC_TXS_IDLE = 1'b0,
        U2DC_TXS_SEND = 1'b1
    } u2dc_txs_e;
endpackage

// File: rtl/u2dc_sync.sv
`timescale 1ns/10ps
module u2dc_sync #(
    parameter int W = 1
) (
    input  wire logic [W-1:0] d,
    input  wire logic         clk,
    input  wire logic         rst,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    // Two stage level synchroniser
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= '0;
            q_reg    <= '0;
        end else begin
            meta_reg <= d;
            q_reg    <= meta_reg;
        end
    end

    assign q = q_reg;
endmodule

// File: rtl/u2dc_cell_port.sv
// How it works
// - Cell bus address 00h selects line port 1, the first port.
// - A port raises its transmit availability bit while it can take a cell.
// - A port drops transmit availability once it cannot take another cell.
// - A port raises receive availability while it holds a complete cell.
// - One edge after enable is seen, the port drives byte one with strobe.
// - A port drops receive availability when it has no more cells.
// - A receive port switch takes one idle edge, then the new cell starts.
// - The receive strobe is high for the first byte only.
// - A deselected port stops and releases its data and strobe outputs.
`timescale 1ns/10ps
module u2dc_cell_port import u2dc_pkg::*; #(
    parameter int PORTS = U2DC_PORTS,
    parameter int CELL  = U2DC_CELL_BYTES,
    parameter int DW    = U2DC_DATA_W,
    parameter int PW    = (PORTS > 1) ? $clog2(PORTS) : 1,
    parameter int IW    = $clog2(CELL + 1)
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    input  wire logic                   ce,
    input  wire logic                   clk_link,
    input  wire logic [U2DC_ADDR_W-1:0] tx_port_select,
    input  wire logic                   tx_cell_enable,
    input  wire logic                   tx_start_of_cell,
    input  wire logic [DW-1:0]          tx_data,
    output logic      [PORTS-1:0]       tx_port_available_vec,
    input  wire logic [U2DC_ADDR_W-1:0] rx_port_select,
    input  wire logic                   rx_cell_enable,
    output logic      [PORTS-1:0]       rx_port_available_vec,
    output logic      [DW-1:0]          rx_data,
    output logic                        rx_start_of_cell,
    output logic                        rx_out_oe,
    output logic                        user_tx_valid,
    input  wire logic                   user_tx_ready,
    output logic      [PW-1:0]          user_tx_port,
    output logic      [DW-1:0]          user_tx_data,
    output logic                        user_tx_sop,
    input  wire logic                   user_rx_valid,
    output logic                        user_rx_ready,
    input  wire logic [PW-1:0]          user_rx_port,
    input  wire logic [DW-1:0]          user_rx_data,
    input  wire logic                   user_rx_sop
);
    localparam logic [IW-1:0] LAST = IW'(CELL - 1);

    function automatic logic [PW:0] port_of(
        input logic [U2DC_ADDR_W-1:0] a
    );
        logic [U2DC_ADDR_W-1:0] o;
        o       = a - U2DC_PORT1_ADDR;
        port_of = {(32'(o) < PORTS), o[PW-1:0]};
    endfunction

    logic [1:0]                  link_ctl;
    logic                        link_rst;
    logic                        ce_l;
    logic [DW-1:0]               tx_mem [PORTS][CELL];
    logic [DW-1:0]               rx_mem [PORTS][CELL];
    logic [PORTS-1:0][IW-1:0]    tx_idx_reg;
    logic [PORTS-1:0][IW-1:0]    tx_idx_next;
    logic [PORTS-1:0]            tx_done_tgl_reg;
    logic [PORTS-1:0]            tx_done_tgl_next;
    logic [PORTS-1:0]            tx_ack_sync;
    logic [PORTS-1:0]            tx_full;
    logic [PW:0]                 tx_hit;
    logic [PW-1:0]               tx_wp;
    logic [IW-1:0]               tx_wa;
    logic                        tx_we;
    logic [PORTS-1:0][IW-1:0]    rx_idx_reg;
    logic [PORTS-1:0][IW-1:0]    rx_idx_next;
    logic [PORTS-1:0]            rx_done_tgl_reg;
    logic [PORTS-1:0]            rx_done_tgl_next;
    logic [PORTS-1:0]            rx_load_sync;
    logic [PW:0]                 rx_sel_reg;
    logic [PW:0]                 rx_sel_next;
    logic [PW-1:0]               rp;
    logic [DW-1:0]               rx_data_reg;
    logic [DW-1:0]               rx_data_next;
    logic                        rx_soc_reg;
    logic                        rx_soc_next;
    logic                        rx_oe_reg;
    logic                        rx_oe_next;
    u2dc_txs_e                   txs_reg;
    u2dc_txs_e                   txs_next;
    logic [PORTS-1:0]            tx_ack_reg;
    logic [PORTS-1:0]            tx_ack_next;
    logic [PORTS-1:0]            tx_done_sync;
    logic [PW-1:0]               utx_port_reg;
    logic [PW-1:0]               utx_port_next;
    logic [IW-1:0]               utx_idx_reg;
    logic [IW-1:0]               utx_idx_next;
    logic [DW-1:0]               utx_data_reg;
    logic [DW-1:0]               utx_data_next;
    logic                        utx_sop_reg;
    logic                        utx_sop_next;
    logic [PORTS-1:0][IW-1:0]    urx_idx_reg;
    logic [PORTS-1:0][IW-1:0]    urx_idx_next;
    logic [PORTS-1:0]            rx_load_tgl_reg;
    logic [PORTS-1:0]            rx_load_tgl_next;
    logic [PORTS-1:0]            rx_done_sync;
    logic [IW-1:0]               urx_wa;
    logic                        urx_we;

    ////////////////////////////////////////////////////////////////////////
    // Crossings
    u2dc_sync #(.W(2)) u_link_ctl (
        .d   ({rst, ce}),
        .clk (clk_link),
        .rst (1'b0),
        .q   (link_ctl)
    );
    assign link_rst = link_ctl[1];
    assign ce_l     = link_ctl[0];

    u2dc_sync #(.W(PORTS)) u_tx_done (
        .d   (tx_done_tgl_reg),
        .clk (clk_sys),
        .rst (rst),
        .q   (tx_done_sync)
    );
    u2dc_sync #(.W(PORTS)) u_tx_ack (
        .d   (tx_ack_reg),
        .clk (clk_link),
        .rst (link_rst),
        .q   (tx_ack_sync)
    );
    u2dc_sync #(.W(PORTS)) u_rx_load (
        .d   (rx_load_tgl_reg),
        .clk (clk_link),
        .rst (link_rst),
        .q   (rx_load_sync)
    );
    u2dc_sync #(.W(PORTS)) u_rx_done (
        .d   (rx_done_tgl_reg),
        .clk (clk_sys),
        .rst (rst),
        .q   (rx_done_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // Link transmit capture
    assign tx_full = tx_done_tgl_reg ^ tx_ack_sync;

    always_comb begin
        tx_hit           = port_of(tx_port_select);
        tx_wp            = tx_hit[PW-1:0];
        tx_idx_next      = tx_idx_reg;
        tx_done_tgl_next = tx_done_tgl_reg;
        tx_we            = 1'b0;
        tx_wa            = tx_start_of_cell ? '0 : tx_idx_reg[tx_wp];
        if (ce_l && tx_cell_enable && tx_hit[PW] && !tx_full[tx_wp]) begin
            if (tx_start_of_cell || tx_idx_reg[tx_wp] != '0) begin
                tx_we = 1'b1;
                if (tx_wa == LAST) begin
                    tx_idx_next[tx_wp]      = '0;
                    tx_done_tgl_next[tx_wp] = !tx_done_tgl_reg[tx_wp];
                end else begin
                    tx_idx_next[tx_wp] = tx_wa + 1'b1;
                end
            end
        end
        for (int p = 0; p < PORTS; p++) begin
            tx_port_available_vec[p] = !tx_full[p] && tx_idx_reg[p] == '0;
        end
    end

    always_ff @(posedge clk_link) begin
        if (link_rst) begin
            tx_idx_reg      <= '0;
            tx_done_tgl_reg <= {PORTS{U2DC_TGL_RST}};
        end else begin
            tx_idx_reg      <= tx_idx_next;
            tx_done_tgl_reg <= tx_done_tgl_next;
        end
        if (tx_we) begin
            tx_mem[tx_wp][tx_wa] <= tx_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link receive delivery
    assign rx_port_available_vec = rx_load_sync ^ rx_done_tgl_reg;

    always_comb begin
        rx_idx_next      = rx_idx_reg;
        rx_done_tgl_next = rx_done_tgl_reg;
        rx_sel_next      = rx_sel_reg;
        rx_data_next     = rx_data_reg;
        rx_soc_next      = rx_soc_reg;
        rx_oe_next       = rx_oe_reg;
        rp               = rx_sel_reg[PW-1:0];
        if (ce_l) begin
            rx_soc_next = 1'b0;
            rx_oe_next  = rx_cell_enable && rx_sel_reg[PW];
            if (!rx_cell_enable) begin
                rx_sel_next = port_of(rx_port_select);
            end else if (rx_sel_reg[PW]) begin
                if (rx_idx_reg[rp] != '0) begin
                    rx_data_next = rx_mem[rp][rx_idx_reg[rp]];
                    if (rx_idx_reg[rp] == LAST) begin
                        rx_idx_next[rp]      = '0;
                        rx_done_tgl_next[rp] = !rx_done_tgl_reg[rp];
                    end else begin
                        rx_idx_next[rp] = rx_idx_reg[rp] + 1'b1;
                    end
                end else if (rx_port_available_vec[rp]) begin
                    rx_data_next    = rx_mem[rp][0];
                    rx_soc_next     = 1'b1;
                    rx_idx_next[rp] = IW'(1);
                end
            end
        end
    end

    always_ff @(posedge clk_link) begin
        if (link_rst) begin
            rx_idx_reg      <= '0;
            rx_done_tgl_reg <= {PORTS{U2DC_TGL_RST}};
            rx_sel_reg      <= '0;
            rx_data_reg     <= '0;
            rx_soc_reg      <= 1'b0;
            rx_oe_reg       <= U2DC_OE_RST;
        end else begin
            rx_idx_reg      <= rx_idx_next;
            rx_done_tgl_reg <= rx_done_tgl_next;
            rx_sel_reg      <= rx_sel_next;
            rx_data_reg     <= rx_data_next;
            rx_soc_reg      <= rx_soc_next;
            rx_oe_reg       <= rx_oe_next;
        end
    end

    assign rx_data          = rx_data_reg;
    assign rx_start_of_cell = rx_soc_reg;
    assign rx_out_oe        = rx_oe_reg;

    ////////////////////////////////////////////////////////////////////////
    // System side transmit drain
    always_comb begin
        logic [PORTS-1:0] pend;
        logic [PW-1:0]    pick;
        pend          = tx_done_sync ^ tx_ack_reg;
        pick          = '0;
        txs_next      = txs_reg;
        tx_ack_next   = tx_ack_reg;
        utx_port_next = utx_port_reg;
        utx_idx_next  = utx_idx_reg;
        utx_data_next = utx_data_reg;
        utx_sop_next  = utx_sop_reg;
        for (int p = PORTS - 1; p >= 0; p--) begin
            if (pend[p]) begin
                pick = PW'(p);
            end
        end
        if (ce) begin
            case (txs_reg)
                U2DC_TXS_IDLE: begin
                    if (pend != '0) begin
                        txs_next      = U2DC_TXS_SEND;
                        utx_port_next = pick;
                        utx_idx_next  = '0;
                        utx_data_next = tx_mem[pick][0];
                        utx_sop_next  = 1'b1;
                    end
                end
                U2DC_TXS_SEND: begin
                    if (user_tx_ready) begin
                        utx_sop_next = 1'b0;
                        if (utx_idx_reg == LAST) begin
                            txs_next                  = U2DC_TXS_IDLE;
                            tx_ack_next[utx_port_reg] = !tx_ack_reg[utx_port_reg];
                        end else begin
                            utx_idx_next  = utx_idx_reg + 1'b1;
                            utx_data_next = tx_mem[utx_port_reg][utx_idx_next];
                        end
                    end
                end
                default: begin
                    txs_next = U2DC_TXS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            txs_reg      <= U2DC_TXS_IDLE;
            tx_ack_reg   <= {PORTS{U2DC_TGL_RST}};
            utx_port_reg <= '0;
            utx_idx_reg  <= '0;
            utx_data_reg <= '0;
            utx_sop_reg  <= 1'b0;
        end else begin
            txs_reg      <= txs_next;
            tx_ack_reg   <= tx_ack_next;
            utx_port_reg <= utx_port_next;
            utx_idx_reg  <= utx_idx_next;
            utx_data_reg <= utx_data_next;
            utx_sop_reg  <= utx_sop_next;
        end
    end

    assign user_tx_valid = (txs_reg == U2DC_TXS_SEND);
    assign user_tx_port  = utx_port_reg;
    assign user_tx_data  = utx_data_reg;
    assign user_tx_sop   = utx_sop_reg;

    ////////////////////////////////////////////////////////////////////////
    // System side receive fill
    assign user_rx_ready = ce
        && (rx_load_tgl_reg[user_rx_port] == rx_done_sync[user_rx_port]);

    always_comb begin
        urx_idx_next     = urx_idx_reg;
        rx_load_tgl_next = rx_load_tgl_reg;
        urx_we           = 1'b0;
        urx_wa           = user_rx_sop ? '0 : urx_idx_reg[user_rx_port];
        if (user_rx_valid && user_rx_ready
            && (user_rx_sop || urx_idx_reg[user_rx_port] != '0)) begin
            urx_we = 1'b1;
            if (urx_wa == LAST) begin
                urx_idx_next[user_rx_port]     = '0;
                rx_load_tgl_next[user_rx_port] = !rx_load_tgl_reg[user_rx_port];
            end else begin
                urx_idx_next[user_rx_port] = urx_wa + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            urx_idx_reg     <= '0;
            rx_load_tgl_reg <= {PORTS{U2DC_TGL_RST}};
        end else begin
            urx_idx_reg     <= urx_idx_next;
            rx_load_tgl_reg <= rx_load_tgl_next;
        end
        if (urx_we) begin
            rx_mem[user_rx_port][urx_wa] <= user_rx_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_rx_ready;
        ce_l && rx_cell_enable && rx_sel_reg[PW]
            && rx_port_available_vec[rp] && rx_idx_reg[rp] == '0;
    endsequence

    sequence s_rx_switch;
        (ce_l && !rx_cell_enable
            && port_of(rx_port_select) == {1'b1, PW'(1)}
            && rx_port_available_vec[1] && rx_idx_reg[1] == '0)
        ##1 (ce_l && rx_cell_enable);
    endsequence

    property p_port1_map;
        @(posedge clk_link) disable iff (link_rst)
        (ce_l && !rx_cell_enable && rx_port_select == U2DC_PORT1_ADDR)
            |=> rx_sel_reg == {1'b1, PW'(0)};
    endproperty
    a_port1_map: assert property (p_port1_map)
        else $error("address 00h did not select port 1");

    property p_tx_avail_drop;
        @(posedge clk_link) disable iff (link_rst)
        (ce_l && tx_cell_enable && tx_start_of_cell && tx_hit[PW]
            && tx_port_available_vec[tx_wp])
            |=> !tx_port_available_vec[$past(tx_wp)];
    endproperty
    a_tx_avail_drop: assert property (p_tx_avail_drop)
        else $error("tx availability stayed high after cell start");

    property p_tx_ignore;
        @(posedge clk_link) disable iff (link_rst)
        !(ce_l && tx_cell_enable && tx_hit[PW])
            |=> $stable(tx_idx_reg) && $stable(tx_done_tgl_reg);
    endproperty
    a_tx_ignore: assert property (p_tx_ignore)
        else $error("tx bus taken while not addressed and enabled");

    property p_rx_start;
        @(posedge clk_link) disable iff (link_rst)
        s_rx_ready |=> rx_start_of_cell && rx_out_oe ##1 !rx_start_of_cell;
    endproperty
    a_rx_start: assert property (p_rx_start)
        else $error("rx cell did not start one edge after enable");

    property p_rx_switch;
        @(posedge clk_link) disable iff (link_rst)
        s_rx_switch |=> rx_start_of_cell && rx_sel_reg == {1'b1, PW'(1)};
    endproperty
    a_rx_switch: assert property (p_rx_switch)
        else $error("new rx port did not start after switch");

    property p_rx_soc_once;
        @(posedge clk_link) disable iff (link_rst)
        (ce_l && rx_soc_reg) |=> !rx_soc_reg;
    endproperty
    a_rx_soc_once: assert property (p_rx_soc_once)
        else $error("rx strobe high past the first byte");

    property p_rx_release;
        @(posedge clk_link) disable iff (link_rst)
        (ce_l && !rx_cell_enable) |=> !rx_out_oe && !rx_start_of_cell;
    endproperty
    a_rx_release: assert property (p_rx_release)
        else $error("rx outputs driven while deselected");

    property p_rx_avail_drop;
        @(posedge clk_link) disable iff (link_rst)
        (ce_l && rx_cell_enable && rx_sel_reg[PW] && rx_idx_reg[rp] == LAST)
            |=> !rx_port_available_vec[$past(rp)];
    endproperty
    a_rx_avail_drop: assert property (p_rx_avail_drop)
        else $error("rx availability high after last byte");
endmodule

// File: bench/u2dc_master_model.sv
`timescale 1ns/10ps
module u2dc_master_model import u2dc_pkg::*; (
    input  wire logic                   clk_link,
    output logic      [U2DC_ADDR_W-1:0] tx_port_select,
    output logic                        tx_cell_enable,
    output logic                        tx_start_of_cell,
    output logic      [U2DC_DATA_W-1:0] tx_data,
    output logic      [U2DC_ADDR_W-1:0] rx_port_select,
    output logic                        rx_cell_enable,
    input  wire logic [U2DC_DATA_W-1:0] rx_data,
    input  wire logic                   rx_start_of_cell,
    input  wire logic                   rx_out_oe
);
    logic [U2DC_DATA_W-1:0] cap_data [U2DC_CELL_BYTES];
    logic                   cap_soc  [U2DC_CELL_BYTES];
    logic                   cap_oe;

    initial begin
        tx_port_select   = 5'h1F;
        tx_cell_enable   = 1'b0;
        tx_start_of_cell = 1'b0;
        tx_data          = 8'h00;
        rx_port_select   = 5'h1F;
        rx_cell_enable   = 1'b0;
    end

    task automatic tick();
        @(posedge clk_link);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Three stray start-of-cell bytes that the port must not take
    task automatic junk(input logic [4:0] sel, input logic en);
        tx_port_select   = sel;
        tx_cell_enable   = en;
        tx_start_of_cell = 1'b1;
        repeat (3) begin
            tx_data = ~tx_data;
            tick();
        end
        tx_cell_enable   = 1'b0;
        tx_start_of_cell = 1'b0;
    endtask

    // Switch cycle, then a whole cell
    task automatic send_cell(input logic [4:0] sel, input logic [7:0] base);
        tx_cell_enable = 1'b0;
        tx_port_select = sel;
        tick();
        for (int i = 0; i < U2DC_CELL_BYTES; i++) begin
            tx_cell_enable   = 1'b1;
            tx_start_of_cell = (i == 0);
            tx_data          = base + 8'(i);
            tick();
        end
        tx_cell_enable   = 1'b0;
        tx_start_of_cell = 1'b0;
        tx_data          = ~tx_data;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Switch cycle, then capture a whole cell
    task automatic recv_cell(input logic [4:0] sel);
        rx_cell_enable = 1'b0;
        rx_port_select = sel;
        tick();
        rx_cell_enable = 1'b1;
        for (int i = 0; i < U2DC_CELL_BYTES; i++) begin
            tick();
            cap_data[i] = rx_out_oe ? rx_data : ~rx_data;
            cap_soc[i]  = rx_out_oe ? rx_start_of_cell : !rx_start_of_cell;
        end
        cap_oe         = rx_out_oe;
        rx_cell_enable = 1'b0;
    endtask
endmodule

// File: bench/tb_utopia2_direct_cell_port.sv
`timescale 1ns/10ps
module tb_utopia2_direct_cell_port import u2dc_pkg::*; ;
    logic       clk_sys, clk_link, rst, tx_en, tx_soc, rx_en, ce;
    logic [4:0] tx_sel, rx_sel;
    logic [7:0] tx_data, rx_data, ut_data, ur_data;
    logic [3:0] tx_avail, rx_avail;
    logic       rx_soc, rx_oe, ut_valid, ut_ready, ut_sop;
    logic       ur_valid, ur_ready, ur_sop;
    logic [1:0] ut_port, ur_port;
    logic [31:0] rng;
    logic [7:0]  bases [4];
    int          bad_count, n_tests;
    int          order [4] = '{0, 2, 3, 1};

    always #12.5 clk_sys = ~clk_sys;
    initial begin
        clk_link = 1'b0;
        #4.3;
        forever #15 clk_link = ~clk_link;
    end

    u2dc_cell_port u_dut (
        .clk_sys(clk_sys), .rst(rst), .ce(ce), .clk_link(clk_link),
        .tx_port_select(tx_sel), .tx_cell_enable(tx_en),
        .tx_start_of_cell(tx_soc), .tx_data(tx_data),
        .tx_port_available_vec(tx_avail), .rx_port_select(rx_sel),
        .rx_cell_enable(rx_en), .rx_port_available_vec(rx_avail),
        .rx_data(rx_data), .rx_start_of_cell(rx_soc), .rx_out_oe(rx_oe),
        .user_tx_valid(ut_valid), .user_tx_ready(ut_ready),
        .user_tx_port(ut_port), .user_tx_data(ut_data),
        .user_tx_sop(ut_sop), .user_rx_valid(ur_valid),
        .user_rx_ready(ur_ready), .user_rx_port(ur_port),
        .user_rx_data(ur_data), .user_rx_sop(ur_sop));

    u2dc_master_model u_m (
        .clk_link(clk_link), .tx_port_select(tx_sel),
        .tx_cell_enable(tx_en), .tx_start_of_cell(tx_soc),
        .tx_data(tx_data), .rx_port_select(rx_sel),
        .rx_cell_enable(rx_en), .rx_data(rx_data),
        .rx_start_of_cell(rx_soc), .rx_out_oe(rx_oe));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] nxt();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng[7:0];
    endfunction

    function automatic logic [7:0] cell_byte(input logic [7:0] b, int i);
        return b + 8'(i);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Drain one cell with random stalls
    task automatic drain(input int p);
        int i;
        int w;
        i = 0;
        w = 0;
        while (i < U2DC_CELL_BYTES && w < 3000) begin
            @(posedge clk_sys);
            #1;
            ut_ready = nxt() > 8'h40;
            w++;
            if (ut_valid === 1'b1 && ut_ready) begin
                check(ut_data, cell_byte(bases[p], i));
                check(ut_sop, i == 0);
                check(ut_port, p);
                i++;
            end
        end
        check(i, U2DC_CELL_BYTES);
        @(posedge clk_sys);
        #1;
        ut_ready = 1'b0;
    endtask

    // Load one cell for delivery to the master
    task automatic fill(input int p);
        int i;
        int w;
        i = 0;
        w = 0;
        bases[p] = nxt();
        while (i < U2DC_CELL_BYTES && w < 1000) begin
            @(posedge clk_sys);
            #1;
            ur_valid = nxt() > 8'h30;
            ur_port  = 2'(p);
            ur_data  = cell_byte(bases[p], i);
            ur_sop   = (i == 0);
            #1;
            if (ur_valid && ur_ready === 1'b1) begin
                i++;
            end
            w++;
        end
        check(i, U2DC_CELL_BYTES);
        @(posedge clk_sys);
        #1;
        ur_valid = 1'b0;
        check(ur_ready, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        rst = 1'b1;
        ut_ready = 1'b0;
        ur_valid = 1'b0;
        ur_port = 2'h0;
        ur_data = 8'h00;
        ur_sop = 1'b0;
        ce = 1'b1;
        rng = 32'hD1F678B1;
        repeat (16) @(posedge clk_sys);
        #1 rst = 1'b0;
        repeat (6) u_m.tick();
        check(tx_avail, 4'hF);
        check(rx_avail, 4'h0);
        check(rx_oe, 1'b0);
        u_m.tick();
        u_m.junk(5'h01, 1'b0);
        u_m.junk(5'h1F, 1'b1);
        @(posedge clk_sys);
        #1 ce = 1'b0;
        repeat (4) u_m.tick();
        u_m.junk(5'h00, 1'b1);
        @(posedge clk_sys);
        #1 ce = 1'b1;
        repeat (20) @(posedge clk_sys);
        #1;
        check(tx_avail, 4'hF);
        check(ut_valid, 1'b0);
        for (int k = 0; k < 4; k += 2) begin
            bases[order[k]] = nxt();
            bases[order[k+1]] = nxt();
            u_m.tick();
            fork
                begin
                    u_m.send_cell(5'(order[k]), bases[order[k]]);
                    check(tx_avail[order[k]], 1'b0);
                    u_m.send_cell(5'(order[k+1]), bases[order[k+1]]);
                    check(tx_avail[order[k+1]], 1'b0);
                end
                begin
                    drain(order[k]);
                    drain(order[k+1]);
                end
            join
            repeat (20) @(posedge clk_sys);
            check(tx_avail, 4'hF);
        end
        fill(0);
        fill(1);
        fill(3);
        repeat (10) u_m.tick();
        check(rx_avail, 4'b1011);
        u_m.tick();
        foreach (order[k]) begin
            if (order[k] != 2) begin
                u_m.recv_cell(5'(order[k]));
                check(rx_avail[order[k]], 1'b0);
                for (int i = 0; i < U2DC_CELL_BYTES; i++) begin
                    check(u_m.cap_data[i], cell_byte(bases[order[k]], i));
                    check(u_m.cap_soc[i], i == 0);
                end
                check(u_m.cap_oe, 1'b1);
            end
        end
        u_m.tick();
        u_m.tick();
        check(rx_oe, 1'b0);
        check(rx_avail, 4'h0);
        check(ur_ready, 1'b1);
        finish_test();
    end

    initial begin
        #300000;
        bad_count++;
        finish_test();
    end
endmodule
